// ===== hw/pat_pkg.sv
/*
 * shared constants, state encoding and the entry address former
 * of the paging address translator.
 * assumes a 32-bit register port and 64-bit table entry reads.
 */
package pat_pkg;
	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int LA_W = 48;
	localparam int PA_W = 52;
	localparam int ENT_W = 64;
	localparam int RA_W = 8;
	localparam int DW = 32;
	localparam int PAGE_SH = 12;
	localparam int LG_IDX_W = 10;
	localparam int LM_IDX_W = 9;
	localparam logic [1:0] LG_TOP = 2'h1;
	localparam logic [1:0] LM_TOP = 2'h3;
	localparam logic [2:0] LG_READS = 3'h2;
	localparam logic [2:0] LM_READS = 3'h4;
	// ----------------------------------------
	// register offsets and bits
	// ----------------------------------------
	localparam logic [RA_W-1:0] OFS_SYS_CTL = 8'h00;
	localparam logic [RA_W-1:0] OFS_ROOT_LO = 8'h04;
	localparam logic [RA_W-1:0] OFS_ROOT_HI = 8'h08;
	localparam logic [RA_W-1:0] OFS_EXT_FEAT = 8'h0C;
	localparam logic [RA_W-1:0] OFS_FLA_LO = 8'h10;
	localparam logic [RA_W-1:0] OFS_FLA_HI = 8'h14;
	localparam logic [RA_W-1:0] OFS_IRQ_STS = 8'h18;
	localparam logic [RA_W-1:0] OFS_IRQ_MSK = 8'h1C;
	localparam int PE_BIT = 0;
	localparam int PG_BIT = 31;
	localparam int LME_BIT = 8;
	localparam int LMA_BIT = 10;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAULT = 1;
	localparam int ENT_P = 0;
	localparam int ENT_RW = 1;
	localparam int ENT_US = 2;
	localparam logic [63:0] ROOT_RST = 64'h0;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_ISSUE = 3'h2,
		ST_WAIT = 3'h4
	} pat_state_type;

	// address of the entry selected by la at level lvl below base
	function automatic logic [PA_W-1:0] pat_entry_addr(
		input logic [PA_W-1:0] base,
		input logic [LA_W-1:0] la,
		input logic [1:0] lvl,
		input logic lm);
		logic [PA_W-1:0] a;
		a = '0;
		if (lm) begin
			a = {base[PA_W-1:PAGE_SH],
				la[PAGE_SH + LM_IDX_W*lvl +: LM_IDX_W], 3'h0};
		end else begin
			a = {base[PA_W-1:PAGE_SH],
				la[PAGE_SH + LG_IDX_W*lvl +: LG_IDX_W], 2'h0};
		end
		return a;
	endfunction
endpackage

// ===== hw/pat_ctl_if.sv
/*
 * control and event signals between register bank and walker.
 * assumes both ends run on the one core clock.
 */
`timescale 1ns/1ns
interface pat_ctl_if import pat_pkg::*; ();
	logic pe;
	logic pg;
	logic long_mode_enable;
	logic long_mode_active;
	logic [63:0] root;
	logic done_ev;
	logic fault_ev;
	logic [LA_W-1:0] fault_la;
	modport regs(output pe, pg, long_mode_enable, long_mode_active, root,
		input done_ev, fault_ev, fault_la);
	modport core(input pe, pg, long_mode_enable, long_mode_active, root,
		output done_ev, fault_ev, fault_la);
endinterface

// ===== hw/pat_regs.sv
/*
 * register bank: control words, translation root, feature enable,
 * fault address capture and interrupt status and mask.
 * assumes single-cycle strobes, never both at once.
 */
`timescale 1ns/1ns
module pat_regs import pat_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [RA_W-1:0] addr,
	input wire logic [DW-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DW-1:0] rdata,
	output logic irq,
	pat_ctl_if.regs ctl
);
	logic pe_q, pg_q, lme_q;
	logic [63:0] root_q;
	logic [LA_W-1:0] fla_q;
	logic [1:0] sts_q, msk_q, ev;
	logic [DW-1:0] rd_val;

	// ----------------------------------------
	// control words
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pe_q <= 1'b0;
			pg_q <= 1'b0;
			lme_q <= 1'b0;
		end else if (wr && addr == OFS_SYS_CTL) begin
			pe_q <= wdata[PE_BIT];
			pg_q <= wdata[PG_BIT] & wdata[PE_BIT];
		end else if (wr && addr == OFS_EXT_FEAT && !pg_q) begin
			// (RULE_12) long mode enable bit
			// mode switch only while paging is off, never mid-walk
			lme_q <= wdata[LME_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			root_q <= ROOT_RST;
		end else if (wr && addr == OFS_ROOT_LO) begin
			root_q[31:0] <= wdata;
		end else if (wr && addr == OFS_ROOT_HI) begin
			root_q[63:32] <= wdata;
		end
	end

	// ----------------------------------------
	// events, set wins over write-one clear
	// ----------------------------------------
	assign ev = {ctl.fault_ev, ctl.done_ev};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sts_q <= 2'h0;
			msk_q <= 2'h0;
			fla_q <= '0;
		end else begin
			if (wr && addr == OFS_IRQ_STS) begin
				sts_q <= (sts_q & ~wdata[1:0]) | ev;
			end else begin
				sts_q <= sts_q | ev;
			end
			if (wr && addr == OFS_IRQ_MSK) begin
				msk_q <= wdata[1:0];
			end
			if (ctl.fault_ev) begin
				fla_q <= ctl.fault_la;
			end
		end
	end

	always_comb begin
		rd_val = '0;
		if (addr == OFS_SYS_CTL) begin
			rd_val[PE_BIT] = pe_q;
			rd_val[PG_BIT] = pg_q;
		end else if (addr == OFS_ROOT_LO) begin
			rd_val = root_q[31:0];
		end else if (addr == OFS_ROOT_HI) begin
			rd_val = root_q[63:32];
		end else if (addr == OFS_EXT_FEAT) begin
			rd_val[LME_BIT] = lme_q;
			rd_val[LMA_BIT] = ctl.long_mode_active;
		end else if (addr == OFS_FLA_LO) begin
			rd_val = fla_q[31:0];
		end else if (addr == OFS_FLA_HI) begin
			rd_val[LA_W-33:0] = fla_q[LA_W-1:32];
		end else if (addr == OFS_IRQ_STS) begin
			rd_val[1:0] = sts_q;
		end else if (addr == OFS_IRQ_MSK) begin
			rd_val[1:0] = msk_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= rd ? rd_val : '0;
		end
	end

	assign ctl.pe = pe_q;
	assign ctl.pg = pg_q;
	assign ctl.long_mode_enable = lme_q;
	assign ctl.long_mode_active = lme_q & pg_q & pe_q;
	assign ctl.root = root_q;
	assign irq = |(sts_q & msk_q);
endmodule // pat_regs

// ===== hw/pat_entry.sv
/*
 * decode of one fetched table entry: rights check, next entry
 * address and final physical address.
 * assumes entry data are valid in the cycle they are used.
 */
`timescale 1ns/1ns
module pat_entry import pat_pkg::*; (
	input wire logic [ENT_W-1:0] data,
	input wire logic lm,
	input wire logic [1:0] lvl,
	input wire logic [LA_W-1:0] la,
	input wire logic wr,
	input wire logic us,
	output logic fault,
	output logic [PA_W-1:0] next_addr,
	output logic [PA_W-1:0] paddr
);
	logic [PA_W-1:0] base;

	always_comb begin
		if (lm) begin
			base = {data[PA_W-1:PAGE_SH], 12'h0};
		end else begin
			base = {{(PA_W-32){1'b0}}, data[31:PAGE_SH], 12'h0};
		end
		fault = !data[ENT_P] | (wr & !data[ENT_RW]) |
			(us & !data[ENT_US]);
		next_addr = pat_entry_addr(base, la, 2'(lvl - 2'h1), lm);
		paddr = {base[PA_W-1:PAGE_SH], la[PAGE_SH-1:0]};
	end
endmodule // pat_entry

// ===== hw/pat_translator.sv
/*
 * paging address translator top: register port, walk state
 * machine, table reads and translation result.
 * assumes memory answers each read with one valid pulse, in order.
 */
// The address map and strobed register access were chosen for this implementation.
// Overview of operation
// (RULE_01) paging off: physical address equals linear, no table reads
// (RULE_02) legacy walk starts at the translation root register base
// (RULE_03) linear address splits into directory, table and offset fields
// (RULE_04) directory entry gives table base plus rights bits
// (RULE_05) table entry gives frame base; offset appended for result
// (RULE_06) reloading root selects another hierarchy for the next walk
// (RULE_07) long mode walks four levels instead of two
// (RULE_08) long mode starts at root; top entry gives pointer table
// (RULE_09) pointer entry gives directory base; lower levels as legacy
// (RULE_10) root and control registers hold 64 bits (only the root register here; control words are single 32-bit words)
// (RULE_11) long mode translation governed by feature enable register
// (RULE_12) enable bit 8 with paging on; active flag shows at bit 10 (bit 8 is only writable here while paging is off)
// (RULE_13) not present or forbidden access aborts walk with fault
// (RULE_14) one table read at a time, strictly in order
`timescale 1ns/1ns
module pat_translator import pat_pkg::*; (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [RA_W-1:0] REG_ADDR,
	input wire logic [DW-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [DW-1:0] REG_RDATA,
	output logic IRQ,
	input wire logic XLT_REQ,
	input wire logic [LA_W-1:0] XLT_LADDR,
	input wire logic XLT_WRITE,
	input wire logic XLT_USER,
	output logic XLT_READY,
	output logic XLT_DONE,
	output logic XLT_FAULT,
	output logic [PA_W-1:0] XLT_PADDR,
	output logic MEM_RD_REQ,
	output logic [PA_W-1:0] MEM_ADDR,
	input wire logic MEM_RD_VALID,
	input wire logic [ENT_W-1:0] MEM_RD_DATA
);
	pat_ctl_if ctl ();
	pat_state_type st_q;
	logic [LA_W-1:0] la_q;
	logic wr_q, us_q, lm_q;
	logic [1:0] lvl_q;
	logic [PA_W-1:0] addr_q;
	logic [PA_W-1:0] root_base;
	logic paging_on, take, ent_fault, ent_ok;
	logic [PA_W-1:0] ent_next, ent_paddr;
	logic done_q, fault_q;
	logic [PA_W-1:0] paddr_q;

	// ----------------------------------------
	// register bank
	// ----------------------------------------
	pat_regs u_regs (
		.clk(CLK),
		.rst_n(RESET_N),
		.addr(REG_ADDR),
		.wdata(REG_WDATA),
		.wr(REG_WR),
		.rd(REG_RD),
		.rdata(REG_RDATA),
		.irq(IRQ),
		.ctl(ctl.regs)
	);

	pat_entry u_entry (
		.data(MEM_RD_DATA),
		.lm(lm_q),
		.lvl(lvl_q),
		.la(la_q),
		.wr(wr_q),
		.us(us_q),
		.fault(ent_fault),
		.next_addr(ent_next),
		.paddr(ent_paddr)
	);

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	assign paging_on = ctl.pg & ctl.pe;
	assign XLT_READY = (st_q == ST_IDLE);
	assign take = XLT_REQ & XLT_READY;
	assign ent_ok = (st_q == ST_WAIT) & MEM_RD_VALID & !ent_fault;

	// (RULE_10) root base, 64-bit register in long mode
	// (RULE_11) mode chosen by long mode active, not paging alone
	always_comb begin
		if (ctl.long_mode_active) begin
			root_base = {ctl.root[PA_W-1:PAGE_SH], 12'h0};
		end else begin
			root_base = {{(PA_W-32){1'b0}},
				ctl.root[31:PAGE_SH], 12'h0};
		end
	end

	// ----------------------------------------
	// walk state machine
	// ----------------------------------------
	// (RULE_14) one read outstanding
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_q <= ST_IDLE;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (take && paging_on) begin
						st_q <= ST_ISSUE;
					end
				end
				ST_ISSUE: begin
					st_q <= ST_WAIT;
				end
				ST_WAIT: begin
					// (RULE_13) fault aborts walk
					if (MEM_RD_VALID) begin
						if (ent_fault || lvl_q == 2'h0) begin
							st_q <= ST_IDLE;
						end else begin
							st_q <= ST_ISSUE;
						end
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// request is held for the whole walk
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			la_q <= '0;
			wr_q <= 1'b0;
			us_q <= 1'b0;
			lm_q <= 1'b0;
		end else if (take) begin
			la_q <= XLT_LADDR;
			wr_q <= XLT_WRITE;
			us_q <= XLT_USER;
			lm_q <= ctl.long_mode_active;
		end
	end

	// level and entry address
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			lvl_q <= 2'h0;
			addr_q <= '0;
		end else if (take) begin
			// (RULE_07) four levels long, two legacy
			lvl_q <= ctl.long_mode_active ? LM_TOP : LG_TOP;
			// (RULE_02) legacy starts at root
			// (RULE_08) long mode starts at root too
			// (RULE_06) root sampled per walk
			addr_q <= pat_entry_addr(root_base, XLT_LADDR,
				ctl.long_mode_active ? LM_TOP : LG_TOP, ctl.long_mode_active);
		end else if (ent_ok) begin
			// (RULE_04) entry gives next table base
			// (RULE_09) pointer entry gives directory base
			// (RULE_03) next index from linear field
			lvl_q <= 2'(lvl_q - 2'h1);
			addr_q <= ent_next;
		end
	end

	// (RULE_14) read issued only once previous entry arrived
	assign MEM_RD_REQ = (st_q == ST_ISSUE);
	assign MEM_ADDR = addr_q;

	// ----------------------------------------
	// result
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			done_q <= 1'b0;
			fault_q <= 1'b0;
			paddr_q <= '0;
		end else begin
			done_q <= 1'b0;
			fault_q <= 1'b0;
			if (take && !paging_on) begin
				// (RULE_01) pass through untranslated
				done_q <= 1'b1;
				paddr_q <= {{(PA_W-LA_W){1'b0}}, XLT_LADDR};
			end else if (ent_ok && lvl_q == 2'h0) begin
				// (RULE_05) frame base joined with offset
				done_q <= 1'b1;
				paddr_q <= ent_paddr;
			end else if (st_q == ST_WAIT && MEM_RD_VALID) begin
				// (RULE_13) fault when not present or rights fail
				fault_q <= ent_fault;
			end
		end
	end

	assign XLT_DONE = done_q;
	assign XLT_FAULT = fault_q;
	assign XLT_PADDR = paddr_q;
	assign ctl.done_ev = done_q;
	assign ctl.fault_ev = fault_q;
	assign ctl.fault_la = la_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [2:0] rd_cnt_q;
	logic byp_q;
	logic rd_out_q;

	// reads per walk, and whether the walk was bypassed
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rd_cnt_q <= 3'h0;
			byp_q <= 1'b0;
		end else if (take) begin
			rd_cnt_q <= 3'h0;
			byp_q <= !paging_on;
		end else if (MEM_RD_REQ) begin
			rd_cnt_q <= 3'(rd_cnt_q + 3'h1);
		end
	end

	// one table read in flight, from request until its answer
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rd_out_q <= 1'b0;
		end else if (MEM_RD_REQ) begin
			rd_out_q <= 1'b1;
		end else if (MEM_RD_VALID) begin
			rd_out_q <= 1'b0;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	sequence s_take_walk;
		take && paging_on;
	endsequence
	sequence s_entry_ok;
		ent_ok;
	endsequence
	sequence s_read_wait;
		!MEM_RD_REQ && rd_out_q && st_q == ST_WAIT;
	endsequence

	a_bypass_result: assert property ( // RULE_01
		take && !paging_on |=> XLT_DONE &&
		XLT_PADDR[LA_W-1:0] == $past(XLT_LADDR))
		else $error("bypass address changed");
	a_bypass_noread: assert property ( // RULE_01
		take && !paging_on |=> !MEM_RD_REQ [*2])
		else $error("table read with paging off");
	a_legacy_root: assert property ( // RULE_02
		s_take_walk and !ctl.long_mode_active |=> MEM_RD_REQ &&
		MEM_ADDR[31:12] == $past(ctl.root[31:12]) &&
		MEM_ADDR[11:2] == $past(XLT_LADDR[31:22]))
		else $error("legacy first read not from root");
	a_long_root: assert property ( // RULE_08
		s_take_walk and ctl.long_mode_active |=> MEM_RD_REQ &&
		MEM_ADDR[PA_W-1:12] == $past(ctl.root[PA_W-1:12]) &&
		MEM_ADDR[11:3] == $past(XLT_LADDR[47:39]))
		else $error("long first read not from root");
	a_next_base: assert property ( // RULE_04
		s_entry_ok and !lm_q and lvl_q != 2'h0 |=>
		MEM_RD_REQ && MEM_ADDR[31:12] == $past(MEM_RD_DATA[31:12])
		&& MEM_ADDR[11:2] == la_q[21:12])
		else $error("table address not from directory entry");
	a_long_next: assert property ( // RULE_09
		s_entry_ok and lm_q and lvl_q != 2'h0 |=> MEM_RD_REQ &&
		MEM_ADDR[PA_W-1:12] == $past(MEM_RD_DATA[PA_W-1:12]))
		else $error("long next address not from entry");
	a_frame_join: assert property ( // RULE_05
		s_entry_ok and lvl_q == 2'h0 |=> XLT_DONE &&
		XLT_PADDR[11:0] == la_q[11:0] &&
		XLT_PADDR[31:12] == $past(MEM_RD_DATA[31:12]))
		else $error("physical address not frame plus offset");
	a_level_count: assert property ( // RULE_07
		XLT_DONE && !byp_q |->
		rd_cnt_q == (lm_q ? LM_READS : LG_READS))
		else $error("wrong number of walk levels");
	a_fault_stop: assert property ( // RULE_13
		st_q == ST_WAIT && MEM_RD_VALID && ent_fault |=>
		XLT_FAULT && !XLT_DONE && !MEM_RD_REQ && XLT_READY)
		else $error("fault did not abort walk");
	a_single_read: assert property ( // RULE_14
		MEM_RD_REQ |-> !rd_out_q ##1 s_read_wait)
		else $error("read issued before entry returned");
	a_walk_busy: assert property ( // RULE_14
		s_take_walk |=> !XLT_READY && st_q == ST_ISSUE)
		else $error("walk did not leave idle");
	a_mode_pick: assert property ( // RULE_11
		s_take_walk |=> lm_q == $past(ctl.long_mode_enable && ctl.pg))
		else $error("walk mode not from feature enable");
endmodule // pat_translator

// ===== tb/pat_mem_model.sv
/*
 * memory partner: answers table entry reads from a sparse store.
 * assumes one read outstanding; the address is latched with the request.
 */
`timescale 1ns/1ns
module pat_mem_model import pat_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic rd_req,
	input wire logic [PA_W-1:0] addr,
	output logic rd_valid,
	output logic [ENT_W-1:0] rd_data
);
	logic [ENT_W-1:0] mem [logic [PA_W-1:0]];
	logic [PA_W-1:0] a_q;
	logic [ENT_W-1:0] last_q;
	int cnt;
	// ----------------------------------------
	// answer path
	// ----------------------------------------
	// one read at a time
	always @(posedge clk or negedge rst_n) begin
		rd_valid <= 1'b0;
		if (!rst_n) begin
			cnt <= 0;
			last_q <= '0;
		end else if (rd_req) begin
			a_q <= addr;
			cnt <= slow ? 3 : 1;
		end else if (cnt == 1) begin
			rd_valid <= 1'b1;
			last_q <= mem.exists(a_q) ? mem[a_q] : '0;
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
	// idle data is inverted so a late sample never looks valid
	assign rd_data = rd_valid ? last_q : ~last_q;
endmodule // pat_mem_model

// ===== tb/testbench.sv
/*
 * self-checking bench of the paging address translator.
 * assumes the memory partner model and a 10 MHz core clock.
 */
`timescale 1ns/1ns
module testbench import pat_pkg::*;;
	logic CLK, RESET_N, REG_WR, REG_RD, XLT_REQ, XLT_WRITE, XLT_USER;
	logic IRQ, XLT_READY, XLT_DONE, XLT_FAULT, MEM_RD_REQ, MEM_RD_VALID;
	logic [RA_W-1:0] REG_ADDR;
	logic [DW-1:0] REG_WDATA, REG_RDATA, rv;
	logic [LA_W-1:0] XLT_LADDR, la;
	logic [PA_W-1:0] XLT_PADDR, MEM_ADDR, root, pa;
	logic [ENT_W-1:0] MEM_RD_DATA, ent;
	logic slow;
	integer seed = 64;
	int bad_count, n_checks, reads, k;

	pat_translator pat_translator_inst (.CLK, .RESET_N, .REG_ADDR,
		.REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .IRQ, .XLT_REQ,
		.XLT_LADDR, .XLT_WRITE, .XLT_USER, .XLT_READY, .XLT_DONE,
		.XLT_FAULT, .XLT_PADDR, .MEM_RD_REQ, .MEM_ADDR, .MEM_RD_VALID,
		.MEM_RD_DATA);
	pat_mem_model pat_mem_model_inst (.clk(CLK), .rst_n(RESET_N),
		.slow(slow), .rd_req(MEM_RD_REQ), .addr(MEM_ADDR),
		.rd_valid(MEM_RD_VALID), .rd_data(MEM_RD_DATA));

	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end
	always @(posedge CLK) if (MEM_RD_REQ === 1'b1) reads <= reads + 1;

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [63:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [RA_W-1:0] a, input logic [DW-1:0] d);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK);
		REG_WR <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [RA_W-1:0] a, output logic [DW-1:0] d);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK);
		REG_RD <= 1'b0;
		#1 d = REG_RDATA;
	endtask
	// reference walk: lays out tables below r and returns the result
	task automatic build(input logic [PA_W-1:0] r, input bit lm,
		input logic [ENT_W-1:0] last, output logic [PA_W-1:0] p);
		logic [PA_W-1:0] b, a;
		int l;
		b = r;
		for (l = lm ? 3 : 1; l >= 0; l--) begin
			if (lm) a = {b[PA_W-1:12], la[12+9*l +: 9], 3'h0};
			else a = {b[PA_W-1:12], la[12+10*l +: 10], 2'h0};
			b = b + 52'h1000;
			if (l == 0) pat_mem_model_inst.mem[a] = last;
			else pat_mem_model_inst.mem[a] = ENT_W'(b) | 64'h7;
		end
		p = {last[PA_W-1:12], la[11:0]};
	endtask
	task automatic xlt(input logic w, u, f, input int nrd);
		int i;
		int r0;
		@(posedge CLK);
		r0 = reads;
		XLT_REQ <= 1'b1;
		XLT_LADDR <= la;
		XLT_WRITE <= w;
		XLT_USER <= u;
		@(posedge CLK);
		XLT_REQ <= 1'b0;
		#1;
		chk("busy", XLT_READY, nrd == 0);
		for (i = 0; i < 40 && XLT_DONE !== 1'b1
			&& XLT_FAULT !== 1'b1; i++) begin
			@(posedge CLK);
			#1;
		end
		if (i == 40) begin
			bad_count++;
			results();
		end else begin
			chk("fault", XLT_FAULT, f);
			chk("done", XLT_DONE, !f);
			chk("ready", XLT_READY, 1'b1);
			if (!f) chk("paddr", XLT_PADDR, pa);
			if (nrd == 0) chk("latency", i, 0);
			chk("reads", reads - r0, nrd);
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{REG_WR, REG_RD, XLT_REQ, XLT_WRITE, XLT_USER, slow} = '0;
		REG_ADDR = '0;
		REG_WDATA = '0;
		XLT_LADDR = '0;
		RESET_N = 1'b0;
		repeat (6) @(posedge CLK);
		RESET_N <= 1'b1;
		rd(OFS_EXT_FEAT, rv);
		chk("feat_rst", rv, 0);
		rd(8'h40, rv);
		chk("unmapped", rv, 0);
		for (k = 0; k < 4; k++) begin
			la = LA_W'({$random(seed), $random(seed)});
			pa = PA_W'(la);
			xlt(k[0], k[1], 1'b0, 0);
		end
		// two hierarchies, same address, different frames
		wr(OFS_SYS_CTL, 32'h8000_0001);
		la = {16'h0, $random(seed)};
		for (k = 0; k < 2; k++) begin
			root = k ? 52'h0020_0000 : 52'h0040_0000;
			wr(OFS_ROOT_LO, root[31:0]);
			wr(OFS_ROOT_HI, 32'h0);
			ent = {32'h0, $random(seed)} & 64'hFFFF_F000 | 64'h7;
			build(root, 1'b0, ent, pa);
			xlt(1'b0, 1'b0, 1'b0, 2);
		end
		// not present, read-only written, supervisor from user
		wr(OFS_IRQ_MSK, 32'h2);
		wr(OFS_IRQ_STS, 32'h3);
		for (k = 0; k < 3; k++) begin
			la = {16'h0, $random(seed)};
			ent = k == 0 ? 64'h6 : (k == 1 ? 64'h5 : 64'h3);
			build(root, 1'b0, ent | 64'h0055_5000, pa);
			xlt(k == 1, k == 2, 1'b1, 2);
			rd(OFS_FLA_LO, rv);
			chk("fault_la", rv, la[31:0]);
			chk("irq_on", IRQ, 1'b1);
			wr(OFS_IRQ_MSK, 32'h0);
			chk("irq_masked", IRQ, 1'b0);
			wr(OFS_IRQ_MSK, 32'h2);
			wr(OFS_IRQ_STS, 32'h2);
			chk("irq_clear", IRQ, 1'b0);
		end
		// long mode: enable with paging off, then turn paging on
		wr(OFS_SYS_CTL, 32'h1);
		wr(OFS_EXT_FEAT, 32'h100);
		wr(OFS_SYS_CTL, 32'h8000_0001);
		rd(OFS_EXT_FEAT, rv);
		chk("lm_active", rv, 32'h500);
		root = 52'h0_0123_4567_8000;
		wr(OFS_ROOT_LO, root[31:0]);
		wr(OFS_ROOT_HI, {12'h0, root[51:32]});
		rd(OFS_ROOT_HI, rv);
		chk("root_hi", rv, {12'h0, root[51:32]});
		for (k = 0; k < 3; k++) begin
			slow = k[0];
			la = LA_W'({$random(seed), $random(seed)});
			ent = {12'h0, 8'($random(seed)), $random(seed), 12'h7};
			build(root, 1'b1, ent, pa);
			xlt(la[40], la[41], 1'b0, 4);
		end
		results();
	end
endmodule // testbench
